/* File: hdl/acr_top.sv */
// config, calibration registers and output framing of the converter
//
// Behaviour
// R1: clock select bit 7: 0 internal oscillator, 1 external clock input.
// R2: clock divide bit 6 set divides the external clock by eight.
// R3: drive bit 5: 0 full drive, 1 half drive on outputs.
// R4: resolution bit 3: 0 gives 24-bit words, 1 gives 16-bit words.
// R5: link check bit 2 checks received crc and appends output crc.
// R6: received crc mismatch sets the link error flag.
// R7: link error stays set until host writes one to clear it.
// R8: host writes map crc over 0h-1h and 4h-Eh into 0Fh.
// R9: map check on: own crc differs from stored value sets map error.
// R10: status prefix bit 0 puts status byte before each word.
// R11: offset is 24-bit two's complement subtracted from each result.
// R12: offset is subtracted first, gain applied afterwards.
// R13: gain word over 400000h scales result; 400000h is unity.
// R14: with map check off, 0Fh is a plain scratch byte.
// R15: 16-bit mode sends top 16 calibrated bits, low byte dropped.
// R16: calibrated result saturates instead of wrapping on overflow.
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.svh"
module acr_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk,
  output logic conv_tick,
  output logic clk_ext_sel,
  output logic output_drive_strength,
  input wire logic [23:0] raw_data,
  input wire logic raw_valid,
  output logic raw_ready,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic irq
);
  acr_pkg::acr_top_s st;
  acr_pkg::acr_top_s next_st;
  acr_cal_if cal_if ();

  logic [7:0] cfg;
  logic req;
  logic [4:0] idx;
  logic [7:0] rdata;
  logic [2:0] clr;
  logic [2:0] ev;
  logic [7:0] map_crc;
  logic [7:0] sts_byte;
  logic [7:0] first_byte;

  //////////////////////////////////////////////////////////////////////
  // submodules

  acr_clk_src u_clk_src (
    .clk(clk),
    .arst_n(arst_n),
    .ext_clk(ext_clk),
    .sel_ext(cfg[`ACR_CFG_CLK_EXT]),
    .div8(cfg[`ACR_CFG_CLK_DIV]),
    .tick(conv_tick)
  );

  acr_cal u_cal (
    .clk(clk),
    .arst_n(arst_n),
    .bus(cal_if)
  );

  assign cfg = st.regs[`ACR_IDX_CFG];
  assign cal_if.raw = raw_data;
  assign cal_if.in_valid = raw_valid;
  assign raw_ready = cal_if.in_ready;
  assign cal_if.offset = {st.regs[`ACR_IDX_OFF_HI],
                          st.regs[`ACR_IDX_OFF_MID],
                          st.regs[`ACR_IDX_OFF_LO]};
  assign cal_if.gain = {st.regs[`ACR_IDX_GAIN_HI],
                        st.regs[`ACR_IDX_GAIN_MID],
                        st.regs[`ACR_IDX_GAIN_LO]};
  // framer takes a result only when idle
  assign cal_if.res_take = cal_if.res_valid && (st.fsm == acr_pkg::st_idle);

  //////////////////////////////////////////////////////////////////////
  // map crc over the covered bytes

  always_comb begin
    map_crc = `ACR_CRC_INIT;
    for (int i = 0; i < 15; i++) begin
      // R8: covered range 0h-1h, 4h-Eh
      if (i != 2 && i != 3) begin
        map_crc = acr_pkg::crc8_byte(map_crc, st.regs[i]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    rdata = 8'h00;
    if (idx <= `ACR_IDX_MAP_CRC) begin
      rdata = st.regs[idx[3:0]];
    end else if (idx == `ACR_IDX_STS) begin
      rdata = {5'h00, st.sts};
    end else if (idx == `ACR_IDX_IEN) begin
      rdata = {5'h00, st.ien};
    end
  end

  assign idx = wb_adr_i[6:2];
  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign sts_byte = {6'h00, st.sts[`ACR_STS_MAP_ERR],
                     st.sts[`ACR_STS_LINK_ERR]};

  //////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    clr = 3'h0;
    ev = 3'h0;
    first_byte = cal_if.res[23:16];

    // bus slave: one ack per request, unmapped reads zero
    if (req) begin
      next_st.ack = 1'b1;
      next_st.rd = rdata;
      if (wb_we_i && wb_sel_i[0]) begin
        if (idx <= `ACR_IDX_MAP_CRC) begin
          // R14: 0Fh stores like any byte
          next_st.regs[idx[3:0]] = wb_dat_i[7:0];
        end else if (idx == `ACR_IDX_CLR) begin
          clr = wb_dat_i[2:0];
        end else if (idx == `ACR_IDX_IEN) begin
          next_st.ien = wb_dat_i[2:0];
        end
      end
    end
    // reserved config bit always reads zero
    next_st.regs[`ACR_IDX_CFG][`ACR_CFG_RSVD] = 1'b0;

    // received link bytes: last byte is the host crc
    if (rx_valid) begin
      if (rx_last) begin
        // R5: check host crc byte
        // R6: mismatch flags link error
        if (cfg[`ACR_CFG_LINK_CRC] && (rx_byte != st.rx_crc)) begin
          ev[`ACR_STS_LINK_ERR] = 1'b1;
        end
        next_st.rx_crc = `ACR_CRC_INIT;
      end else begin
        next_st.rx_crc = acr_pkg::crc8_byte(st.rx_crc, rx_byte);
      end
    end

    // output framer
    case (st.fsm)
      acr_pkg::st_idle: begin
        if (cal_if.res_valid) begin
          // checked per conversion so partial map writes are not flagged
          // R9: compare map crc
          if (cfg[`ACR_CFG_MAP_CRC] &&
              (map_crc != st.regs[`ACR_IDX_MAP_CRC])) begin
            ev[`ACR_STS_MAP_ERR] = 1'b1;
          end
          next_st.sh = {cal_if.res[15:0], 8'h00};
          // R4: two or three data bytes
          // R15: 16-bit keeps the top bytes
          next_st.bcnt = cfg[`ACR_CFG_RES16] ? 2'h2 : 2'h3;
          // R10: optional status prefix
          if (cfg[`ACR_CFG_STS_PFX]) begin
            next_st.fsm = acr_pkg::st_stat;
            next_st.tx_byte = sts_byte;
            next_st.tx_crc = acr_pkg::crc8_byte(`ACR_CRC_INIT, sts_byte);
            next_st.sh = cal_if.res;
          end else begin
            next_st.fsm = acr_pkg::st_data;
            next_st.tx_byte = first_byte;
            next_st.tx_crc = acr_pkg::crc8_byte(`ACR_CRC_INIT, first_byte);
            next_st.bcnt = next_st.bcnt - 2'h1;
          end
        end
      end
      acr_pkg::st_stat: begin
        if (tx_ready) begin
          next_st.fsm = acr_pkg::st_data;
          next_st.tx_byte = st.sh[23:16];
          next_st.tx_crc = acr_pkg::crc8_byte(st.tx_crc, st.sh[23:16]);
          next_st.sh = {st.sh[15:0], 8'h00};
          next_st.bcnt = st.bcnt - 2'h1;
        end
      end
      acr_pkg::st_data: begin
        if (tx_ready) begin
          if (st.bcnt != 2'h0) begin
            next_st.tx_byte = st.sh[23:16];
            next_st.tx_crc = acr_pkg::crc8_byte(st.tx_crc, st.sh[23:16]);
            next_st.sh = {st.sh[15:0], 8'h00};
            next_st.bcnt = st.bcnt - 2'h1;
          // R5: append output crc
          end else if (cfg[`ACR_CFG_LINK_CRC]) begin
            next_st.fsm = acr_pkg::st_crcb;
            next_st.tx_byte = st.tx_crc;
          end else begin
            next_st.fsm = acr_pkg::st_idle;
            ev[`ACR_STS_DONE] = 1'b1;
          end
        end
      end
      acr_pkg::st_crcb: begin
        if (tx_ready) begin
          next_st.fsm = acr_pkg::st_idle;
          ev[`ACR_STS_DONE] = 1'b1;
        end
      end
      default: begin
        next_st.fsm = acr_pkg::st_idle;
      end
    endcase

    // R7: sticky until written one
    // set beats a clear in the same cycle
    next_st.sts = (st.sts & ~clr) | ev;
  end

  //////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.regs[`ACR_IDX_CFG] <= `ACR_CFG_RST;
      st.regs[`ACR_IDX_GAIN_HI] <= `ACR_GAIN_HI_RST;
      st.fsm <= acr_pkg::st_idle;
      st.tx_crc <= `ACR_CRC_INIT;
      st.rx_crc <= `ACR_CRC_INIT;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_dat_o = {24'h000000, st.rd};
  assign wb_ack_o = st.ack;
  // R1: external clock select out
  assign clk_ext_sel = cfg[`ACR_CFG_CLK_EXT];
  // R3: half drive select
  assign output_drive_strength = cfg[`ACR_CFG_DRV_HALF];
  assign tx_byte = st.tx_byte;
  assign tx_valid = (st.fsm != acr_pkg::st_idle);
  assign irq = |(st.sts & st.ien);
endmodule // acr_top
`default_nettype wire

/* File: hdl/acr_defines.svh */
// offsets, field positions, reset values and timing counts
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
// register indices; byte address is four times the index
`define ACR_IDX_CFG 5'h08
`define ACR_IDX_OFF_HI 5'h09
`define ACR_IDX_OFF_MID 5'h0a
`define ACR_IDX_OFF_LO 5'h0b
`define ACR_IDX_GAIN_HI 5'h0c
`define ACR_IDX_GAIN_MID 5'h0d
`define ACR_IDX_GAIN_LO 5'h0e
`define ACR_IDX_MAP_CRC 5'h0f
`define ACR_IDX_STS 5'h10
`define ACR_IDX_CLR 5'h11
`define ACR_IDX_IEN 5'h12
// configuration fields
`define ACR_CFG_CLK_EXT 7
`define ACR_CFG_CLK_DIV 6
`define ACR_CFG_DRV_HALF 5
`define ACR_CFG_RSVD 4
`define ACR_CFG_RES16 3
`define ACR_CFG_LINK_CRC 2
`define ACR_CFG_MAP_CRC 1
`define ACR_CFG_STS_PFX 0
// status and interrupt fields
`define ACR_STS_LINK_ERR 0
`define ACR_STS_MAP_ERR 1
`define ACR_STS_DONE 2
// reset values and constants
`define ACR_CFG_RST 8'h00
`define ACR_GAIN_HI_RST 8'h40
`define ACR_CRC_POLY 8'h07
`define ACR_CRC_INIT 8'hff
`define ACR_EXT_DIV 3'h7
`define ACR_GAIN_SHIFT 22
`endif

/* File: hdl/acr_pkg.sv */
// types and crc helper for the config and calibration bank
`include "acr_defines.svh"
package acr_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_stat = 2'b01,
    st_data = 2'b11,
    st_crcb = 2'b10
  } acr_fsm_e;

  typedef struct packed {
    logic [15:0][7:0] regs;
    logic [2:0] sts;
    logic [2:0] ien;
    logic ack;
    logic [7:0] rd;
    acr_fsm_e fsm;
    logic [1:0] bcnt;
    logic [23:0] sh;
    logic [7:0] tx_crc;
    logic [7:0] tx_byte;
    logic [7:0] rx_crc;
  } acr_top_s;

  typedef struct packed {
    logic [23:0] res;
    logic valid;
  } acr_cal_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic [2:0] cnt;
    logic tick;
  } acr_clk_s;

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc,
                                           input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `ACR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

/* File: hdl/acr_cal_if.sv */
// carrier between the bank and the calibration datapath
`timescale 1ns/1ps
`default_nettype none
interface acr_cal_if;
  logic [23:0] raw;
  logic in_valid;
  logic in_ready;
  logic [23:0] offset;
  logic [23:0] gain;
  logic [23:0] res;
  logic res_valid;
  logic res_take;
  modport bank (output raw, in_valid, offset, gain, res_take,
                input in_ready, res, res_valid);
  modport cal (input raw, in_valid, offset, gain, res_take,
               output in_ready, res, res_valid);
endinterface
`default_nettype wire

/* File: hdl/acr_cal.sv */
// offset then gain calibration with saturation
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.svh"
module acr_cal (
  input wire logic clk,
  input wire logic arst_n,
  acr_cal_if.cal bus
);
  acr_pkg::acr_cal_s st;
  acr_pkg::acr_cal_s next_st;
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [27:0] scaled;

  always_comb begin
    next_st = st;
    // R11: offset subtract
    diff = $signed({bus.raw[23], bus.raw}) -
           $signed({bus.offset[23], bus.offset});
    // R12: gain after offset
    // R13: gain over 400000h
    prod = diff * $signed({1'b0, bus.gain});
    scaled = 28'(prod >>> `ACR_GAIN_SHIFT);
    if (bus.res_take) begin
      next_st.valid = 1'b0;
    end
    if (bus.in_valid && !st.valid) begin
      next_st.valid = 1'b1;
      // R16: clamp, never wrap
      if (scaled > 28'sh07fffff) begin
        next_st.res = 24'h7fffff;
      end else if (scaled < -28'sh0800000) begin
        next_st.res = 24'h800000;
      end else begin
        next_st.res = scaled[23:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.in_ready = !st.valid;
  assign bus.res = st.res;
  assign bus.res_valid = st.valid;
endmodule // acr_cal
`default_nettype wire

/* File: hdl/acr_clk_src.sv */
// conversion clock pick: internal, external, or external divided by eight
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.svh"
module acr_clk_src (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ext_clk,
  input wire logic sel_ext,
  input wire logic div8,
  output logic tick
);
  acr_pkg::acr_clk_s st;
  acr_pkg::acr_clk_s next_st;
  logic edge_seen;

  always_comb begin
    next_st = st;
    next_st.s1 = ext_clk;
    next_st.s2 = st.s1;
    next_st.prev = st.s2;
    edge_seen = st.s2 && !st.prev;
    if (edge_seen) begin
      next_st.cnt = st.cnt + 3'h1;
    end
    // R1: clock source pick
    if (!sel_ext) begin
      next_st.tick = 1'b1;
    // R2: divide by eight
    end else if (div8) begin
      next_st.tick = edge_seen && (st.cnt == `ACR_EXT_DIV);
    end else begin
      next_st.tick = edge_seen;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // acr_clk_src
`default_nettype wire

/* File: bench/acr_top_assertions.sv */
// concurrent checks on the top ports of the config and calibration bank
`timescale 1ns/1ps
`default_nettype none
module acr_top_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic conv_tick,
  input wire logic clk_ext_sel,
  input wire logic output_drive_strength,
  input wire logic raw_valid,
  input wire logic raw_ready,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic irq
);
  logic wr_cfg;
  logic [7:0] cfg;
  logic [2:0] nb;
  assign wr_cfg = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
    wb_sel_i[0] && wb_adr_i[6:2] == 5'h08;
  // shadow of the config byte; bytes seen in the current frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= 8'h00;
      nb <= 3'h0;
    end else begin
      if (wr_cfg) cfg <= wb_dat_i[7:0];
      nb <= !tx_valid ? 3'h0 : nb + 3'(tx_valid && tx_ready);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sel_follow_a: assert property (wr_cfg |-> ##3
    clk_ext_sel == $past(wb_dat_i[7], 3)) else $error("ext select stale");
  drv_follow_a: assert property (wr_cfg |-> ##3
    output_drive_strength == $past(wb_dat_i[5], 3))
    else $error("drive stale");
  int_tick_a: assert property (!clk_ext_sel [*3] |=> conv_tick)
    else $error("internal tick missing");
  // depth skips the first tick after a switch, whose count was partial
  div_gap_a: assert property (conv_tick && clk_ext_sel && cfg[6] &&
    $past(cfg[6], 48) |=> !conv_tick [*7]) else $error("tick too close");
  frame_len_a: assert property ($fell(tx_valid) |->
    nb == 3'(2 + !cfg[3] + cfg[0] + cfg[2])) else $error("frame length");
  ready_drop_a: assert property (raw_valid && raw_ready |=>
    !raw_ready) else $error("result not held");
  frame_start_a: assert property (raw_valid && raw_ready |->
    ##2 tx_valid) else $error("frame late");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_byte)) else $error("stalled byte changed");
  cover property (conv_tick && clk_ext_sel && cfg[6]);
  cover property ($fell(tx_valid) && cfg[0] && cfg[2]);
  cover property ($rose(irq));
endmodule // acr_top_assertions
////////////////////////////////////////////////////////////////////////
bind acr_top acr_top_assertions chk (.clk(clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .conv_tick(conv_tick), .clk_ext_sel(clk_ext_sel),
  .output_drive_strength(output_drive_strength), .raw_valid(raw_valid),
  .raw_ready(raw_ready), .tx_byte(tx_byte), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .irq(irq));
`default_nettype wire

/* File: bench/acr_host_model.sv */
// host side: framed byte sink with stalls, link byte sender
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic rx_last
);
  logic [7:0] got[$];
  logic ph = 1'b0;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  end
  // half-rate accept when stalling, so the framer must hold its byte
  assign tx_ready = !(stall && ph);
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    ph <= ~ph;
  end
  // one byte a call; the line shows inverted junk once released
  task automatic send(input logic [7:0] b, input logic last);
    rx_byte <= b;
    rx_valid <= 1'b1;
    rx_last <= last;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_byte <= ~b;
    @(posedge clk);
  endtask
endmodule // acr_host_model
`default_nettype wire

/* File: bench/tb_acr_top.sv */
// self-checking bench for the config and calibration bank
`timescale 1ns/1ps
`default_nettype none
module tb_acr_top;
  logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic ext_clk = 1'b0, ext_run = 1'b0, rvld = 1'b0, stall = 1'b1;
  logic ack, tick, esel, drv, rrdy, txv, txr, rxv, rxl, irq;
  logic [6:0] adr = 7'h00;
  logic [3:0] sel = 4'h1;
  logic [31:0] wdat = 32'h0, rdat;
  logic [23:0] raw = 24'h0;
  logic [7:0] txb, rxb, q;
  logic [1:0] ec = 2'h0;
  int num_errors = 0, cmp_count = 0, cyc_n = 0;
  acr_top dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ext_clk(ext_clk), .conv_tick(tick),
    .clk_ext_sel(esel), .output_drive_strength(drv), .raw_data(raw),
    .raw_valid(rvld), .raw_ready(rrdy), .tx_byte(txb), .tx_valid(txv),
    .tx_ready(txr), .rx_byte(rxb), .rx_valid(rxv), .rx_last(rxl), .irq(irq));
  acr_host_model host (.clk(clk), .stall(stall), .tx_byte(txb),
    .tx_valid(txv), .tx_ready(txr), .rx_byte(rxb), .rx_valid(rxv),
    .rx_last(rxl));
  initial begin
    forever #20 clk = ~clk;
  end
  // external clock of four cycles; frozen while config changes
  always @(posedge clk) begin
    if (ext_run) ec <= ec + 2'h1;
    if (ext_run) ext_clk <= ec[1];
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] i, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    // waits for ack as long as it takes; the cycle ceiling ends a hang
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // crc-8, poly 07h, init ffh, msb first
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] b);
    c = c ^ b;
    for (int k = 0; k < 8; k++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic conv(input logic [7:0] cf, input logic [23:0] o, g, r,
    input logic [7:0] bad);
    logic [7:0] e[$];
    logic [7:0] c;
    longint v;
    int n;
    bus(1, 5'h08, cf);
    for (int k = 0; k < 3; k++) begin
      bus(1, 5'(9 + k), o[23 - 8 * k -: 8]);
      bus(1, 5'(12 + k), g[23 - 8 * k -: 8]);
    end
    if (cf[1]) begin
      c = 8'hff;
      for (int i = 0; i < 15; i++) begin
        if (i == 2 || i == 3) continue;
        bus(0, 5'(i), 8'h00);
        c = crc8(c, q);
      end
      bus(1, 5'h0f, c ^ bad);
    end
    v = (longint'($signed(r)) - longint'($signed(o))) * longint'(g);
    v = v >>> 22;
    if (v > 64'sh7fffff) v = 64'sh7fffff;
    if (v < -64'sh800000) v = -64'sh800000;
    if (cf[0]) e.push_back(8'h00);
    e.push_back(v[23:16]);
    e.push_back(v[15:8]);
    if (!cf[3]) e.push_back(v[7:0]);
    c = 8'hff;
    foreach (e[k]) c = crc8(c, e[k]);
    if (cf[2]) e.push_back(c);
    host.got.delete();
    raw <= r;
    rvld <= 1'b1;
    @(posedge clk);
    rvld <= 1'b0;
    for (n = 0; n < 200 && !(n > 3 && txv === 1'b0); n++) @(posedge clk);
    check("frame length", host.got.size(), e.size());
    foreach (e[k]) check("frame byte", host.got[k], e[k]);
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      bus(0, 5'(8 + i), 8'h00);
      check("reset value", q, i == 4 ? 8'h40 : 8'h00);
    end
    bus(1, 5'h08, 8'hff);
    bus(0, 5'h08, 8'h00);
    check("config", q, 8'hef);
    check("ext select", esel, 1'b1);
    check("half drive", drv, 1'b1);
    bus(0, 5'h13, 8'h00);
    check("unmapped", q, 8'h00);
    $display("register test done");
  endtask
  task automatic t_clk();
    int n;
    for (int j = 0; j < 3; j++) begin
      ext_run <= 1'b0;
      bus(1, 5'h08, {j != 0, j == 2, 6'h00});
      ext_run <= 1'b1;
      repeat (48) @(posedge clk);
      n = 0;
      repeat (j == 0 ? 20 : j == 1 ? 40 : 320) begin
        @(posedge clk);
        n += tick;
      end
      check("tick count", n, j == 0 ? 20 : 10);
    end
    ext_run <= 1'b0;
    bus(1, 5'h08, 8'h00);
    check("full drive", drv, 1'b0);
    $display("clock test done");
  endtask
  task automatic t_cal();
    conv(8'h00, 24'h000010, 24'h400000, 24'h000100, 8'h00);
    conv(8'h00, 24'hfffff0, 24'h800000, 24'h000010, 8'h00);
    conv(8'h08, 24'h000000, 24'h800000, 24'h600000, 8'h00);
    conv(8'h05, 24'h000000, 24'h800000, 24'h900000, 8'h00);
    conv(8'h0d, 24'h123456, 24'h3fffff, 24'h7abcde, 8'h00);
    $display("calibration test done");
  endtask
  task automatic t_link();
    bus(1, 5'h08, 8'h04);
    bus(1, 5'h12, 8'h01);
    host.send(8'h3c, 1'b0);
    host.send(8'ha5, 1'b0);
    host.send(crc8(crc8(8'hff, 8'h3c), 8'ha5), 1'b1);
    bus(0, 5'h10, 8'h00);
    check("good crc", q[0], 1'b0);
    host.send(8'h3c, 1'b0);
    host.send(~crc8(8'hff, 8'h3c), 1'b1);
    bus(0, 5'h10, 8'h00);
    check("bad crc", q[0], 1'b1);
    check("irq raised", irq, 1'b1);
    bus(1, 5'h11, 8'h02);
    bus(0, 5'h10, 8'h00);
    check("sticky", q[0], 1'b1);
    bus(1, 5'h12, 8'h00);
    check("irq masked", irq, 1'b0);
    bus(1, 5'h12, 8'h01);
    bus(1, 5'h11, 8'h01);
    bus(0, 5'h10, 8'h00);
    check("cleared", q[0], 1'b0);
    check("irq low", irq, 1'b0);
    $display("link test done");
  endtask
  task automatic t_map();
    bus(1, 5'h0f, 8'h5a);
    bus(0, 5'h0f, 8'h00);
    check("scratch", q, 8'h5a);
    sel <= 4'h0;
    bus(1, 5'h0f, 8'ha5);
    sel <= 4'h1;
    bus(0, 5'h0f, 8'h00);
    check("masked write", q, 8'h5a);
    conv(8'h00, 24'h0, 24'h400000, 24'h000100, 8'h00);
    bus(0, 5'h10, 8'h00);
    check("map off", q[1], 1'b0);
    conv(8'h02, 24'h0, 24'h400000, 24'h000100, 8'h00);
    bus(0, 5'h10, 8'h00);
    check("map match", q[1], 1'b0);
    conv(8'h02, 24'h0, 24'h400000, 24'h000100, 8'h01);
    bus(0, 5'h10, 8'h00);
    check("map mismatch", q[1], 1'b1);
    $display("map test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_clk();
    t_cal();
    t_link();
    t_map();
    report_and_stop();
  end
endmodule // tb_acr_top
`default_nettype wire
